// ---- common/kcrc_params.svh ----
// Constants for the keyscan clock and reset control block
`ifndef KCRC_PARAMS_SVH
`define KCRC_PARAMS_SVH

// ==========================================================================
// Clock rates and dividers
`define KCRC_CLK_HZ 40000000
`define KCRC_EXEC_HZ 2000000
`define KCRC_EXEC_DIV (`KCRC_CLK_HZ / `KCRC_EXEC_HZ)
`define KCRC_PWM_DIV 64

// ==========================================================================
// Reset timing
`define KCRC_RESET_HOLD_NS 700
`define KCRC_RESET_HOLD_CYC ((`KCRC_RESET_HOLD_NS * (`KCRC_CLK_HZ / 1000000) + 999) / 1000)
`define KCRC_RESET_RELEASE_NS 1400
`define KCRC_RESET_RELEASE_CYC ((`KCRC_RESET_RELEASE_NS * (`KCRC_CLK_HZ / 1000000)) / 1000)
`define KCRC_POR_PRESET 8'hFF

// ==========================================================================
// Inactivity timing
`define KCRC_UNIT_MS 4
`define KCRC_UNIT_CYC (`KCRC_UNIT_MS * (`KCRC_CLK_HZ / 1000))
`define KCRC_ACTIVE_MS 500
`define KCRC_ACTIVE_DEFAULT (`KCRC_ACTIVE_MS / `KCRC_UNIT_MS)

// ==========================================================================
// Clock configuration register layout
`define KCRC_CFG_BUF_BIT 6
`define KCRC_CFG_EXTSEL_BIT 3
`define KCRC_CFG_SRC_LSB 0
`define KCRC_CFG_MASK 8'h4B
`define KCRC_CFG_RESET 8'h08
`define KCRC_SRC_PRESCALED 2'h0
`define KCRC_SRC_EXTERNAL 2'h3

`endif

// ---- common/kcrc_pkg.sv ----
// Types for the keyscan clock and reset control block
package kcrc_pkg;

	// ==========================================================================
	// Operating mode
	typedef enum logic {
		KCRC_RUN,
		KCRC_HALT
	} kcrc_mode_type;

	// ==========================================================================
	// Pin control carrier; drive bits mean the pin is driven low
	typedef struct packed {
		logic [7:0] scanInPullup;
		logic [11:0] scanOutDrive;
		logic scanOut8Clock;
		logic irqDrive;
		logic [2:0] pwmDrive;
		logic busDataDrive;
		logic busClockDrive;
		logic xtalOutPullup;
		logic crystalOscEnable;
	} kcrc_pin_type;

	// ==========================================================================
	// Whole block state
	typedef struct packed {
		logic [1:0] rstSync;
		logic [7:0] porCount;
		logic porActive;
		logic inReset;
		logic initDone;
		logic [4:0] execDiv;
		logic execEn;
		logic [5:0] pwmDiv;
		logic [7:0] clockCfg;
		logic [1:0] activeSrc;
		logic tbLevel;
		logic tbTick;
		logic bufOut;
		logic [17:0] unitCount;
		logic [7:0] idleUnits;
		logic [7:0] activeTime;
		kcrc_mode_type mode;
		logic halted;
		logic nackFirst;
		kcrc_pin_type pins;
	} kcrc_state_type;

endpackage

// ---- logic/kcrc_top.sv ----
// Clock generation, halt control and reset sequencing for the keyscan companion
`include "kcrc_params.svh"

module kcrc_top #(
	parameter int UNIT_CYCLES = `KCRC_UNIT_CYC,
	parameter int EXEC_DIV = `KCRC_EXEC_DIV,
	parameter logic [7:0] ACTIVE_DEFAULT = 8'(`KCRC_ACTIVE_DEFAULT)
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Reset sources
	input wire logic resetPinN,
	input wire logic supplyOk,
	input wire logic resetCommand,
	// Host command strobes
	input wire logic clockWrite,
	input wire logic [7:0] clockData,
	input wire logic activeTimeWrite,
	input wire logic [7:0] activeTimeData,
	input wire logic initComplete,
	// Activity and bus
	input wire logic keyEvent,
	input wire logic busStart,
	input wire logic busCycleDone,
	input wire logic encoderChange,
	input wire logic encoderEnable,
	input wire logic busDataPullLow,
	input wire logic busClockPullLow,
	// Slow clock pins
	input wire logic slowClockInput,
	input wire logic crystalInPin,
	// Clock outputs
	output logic execEnable,
	output logic pwmTimebaseTick,
	output logic bufferedTimebaseOut,
	output logic [7:0] clockConfig,
	// Status
	output logic coreReset,
	output logic haltActive,
	output logic nackFirstCycle,
	// Pin control
	output kcrc_pkg::kcrc_pin_type pinControl
);

	// ==========================================================================
	// Elaboration checks
	if (UNIT_CYCLES < 1 || UNIT_CYCLES >= (1 << 18)) begin : g_bad_unit
		$error("UNIT_CYCLES out of range");
	end
	if (EXEC_DIV < 2 || EXEC_DIV > 32) begin : g_bad_div
		$error("EXEC_DIV out of range");
	end

	// ==========================================================================
	// State
	kcrc_pkg::kcrc_state_type s;
	kcrc_pkg::kcrc_state_type next_s;
	logic activity;
	logic preLevel;
	logic extLevel;
	logic curLevel;
	logic newLevel;
	logic [1:0] reqSrc;

	assign activity = keyEvent | busStart | (encoderChange & encoderEnable);

	always_comb begin
		next_s = s;
		next_s.execEn = 1'b0;
		next_s.tbTick = 1'b0;

		// Pin reset enters through a two-stage synchroniser
		next_s.rstSync = {s.rstSync[0], resetPinN};

		// Power-on countdown on the execution clock; command reuses it
		if (!supplyOk || resetCommand) begin
			next_s.porCount = `KCRC_POR_PRESET;
			next_s.porActive = 1'b1;
		end else if (s.porActive && s.execEn) begin
			if (s.porCount == 8'h00) begin
				next_s.porActive = 1'b0;
			end else begin
				next_s.porCount = s.porCount - 8'h01;
			end
		end
		// Pin release does not rerun the countdown, so it stays well inside 1400 ns
		next_s.inReset = ~s.rstSync[1] | next_s.porActive | resetCommand;

		// Halt control
		next_s.unitCount = s.unitCount;
		case (s.mode)
			kcrc_pkg::KCRC_RUN: begin
				if (activity) begin
					next_s.unitCount = 18'h00000;
					next_s.idleUnits = 8'h00;
				end else if (s.activeTime != 8'h00 && s.idleUnits >= s.activeTime) begin
					next_s.mode = kcrc_pkg::KCRC_HALT;
				end else if (s.unitCount == 18'(UNIT_CYCLES - 1)) begin
					next_s.unitCount = 18'h00000;
					next_s.idleUnits = s.idleUnits + 8'h01;
				end else begin
					next_s.unitCount = s.unitCount + 18'h00001;
				end
			end
			kcrc_pkg::KCRC_HALT: begin
				if (activity || !s.rstSync[1]) begin
					next_s.mode = kcrc_pkg::KCRC_RUN;
					next_s.unitCount = 18'h00000;
					next_s.idleUnits = 8'h00;
				end
			end
			default: begin
				next_s.mode = kcrc_pkg::KCRC_RUN;
			end
		endcase

		// First bus cycle after a bus wake is refused; a new wake beats the clear
		if (busCycleDone) begin
			next_s.nackFirst = 1'b0;
		end
		if (s.mode == kcrc_pkg::KCRC_HALT && busStart) begin
			next_s.nackFirst = 1'b1;
		end

		// Execution clock enable, stopped while halted
		if (s.mode == kcrc_pkg::KCRC_HALT && !s.inReset) begin
			next_s.execDiv = s.execDiv;
		end else if (s.execDiv == 5'(EXEC_DIV - 1)) begin
			next_s.execDiv = 5'h00;
			next_s.execEn = 1'b1;
		end else begin
			next_s.execDiv = s.execDiv + 5'h01;
		end
		if (s.execEn) begin
			next_s.pwmDiv = s.pwmDiv + 6'h01;
		end

		// Host writes; reserved bits are forced to zero
		if (clockWrite && !s.inReset) begin
			next_s.clockCfg = clockData & `KCRC_CFG_MASK;
		end
		if (activeTimeWrite && !s.inReset) begin
			next_s.activeTime = activeTimeData;
		end
		if (initComplete && !s.inReset) begin
			next_s.initDone = 1'b1;
		end

		// Timebase source selection
		preLevel = s.pwmDiv[5];
		extLevel = s.clockCfg[`KCRC_CFG_EXTSEL_BIT] ? slowClockInput : crystalInPin;
		// Reserved codes fall back to the prescaled source
		reqSrc = (s.clockCfg[`KCRC_CFG_SRC_LSB +: 2] == `KCRC_SRC_EXTERNAL) ?
			`KCRC_SRC_EXTERNAL : `KCRC_SRC_PRESCALED;
		curLevel = (s.activeSrc == `KCRC_SRC_EXTERNAL) ? extLevel : preLevel;
		newLevel = (reqSrc == `KCRC_SRC_EXTERNAL) ? extLevel : preLevel;
		// Hand over only while old and new are both low: no runt, no extra edge
		if (reqSrc != s.activeSrc && !s.tbLevel && !curLevel && !newLevel) begin
			next_s.activeSrc = reqSrc;
		end
		next_s.tbLevel = curLevel;
		next_s.tbTick = curLevel & ~s.tbLevel;
		next_s.bufOut = s.clockCfg[`KCRC_CFG_BUF_BIT] & curLevel;

		// Halt, idle, host and source state returns to defaults under any reset; the clock dividers keep running
		if (next_s.inReset) begin
			next_s.mode = kcrc_pkg::KCRC_RUN;
			next_s.unitCount = 18'h00000;
			next_s.idleUnits = 8'h00;
			next_s.activeTime = ACTIVE_DEFAULT;
			next_s.clockCfg = `KCRC_CFG_RESET;
			next_s.activeSrc = `KCRC_SRC_PRESCALED;
			next_s.initDone = 1'b0;
			next_s.nackFirst = 1'b0;
			next_s.bufOut = 1'b0;
		end
		next_s.halted = (next_s.mode == kcrc_pkg::KCRC_HALT);

		// Pin configuration follows the reset and init phase of the next state
		next_s.pins = '0;
		next_s.pins.xtalOutPullup = 1'b1;
		next_s.pins.crystalOscEnable = ~next_s.clockCfg[`KCRC_CFG_EXTSEL_BIT];
		next_s.pins.busDataDrive = busDataPullLow & ~next_s.inReset;
		next_s.pins.busClockDrive = busClockPullLow & ~next_s.inReset;
		if (!next_s.inReset && next_s.initDone) begin
			next_s.pins.scanInPullup = 8'h07;
			next_s.pins.scanOutDrive = 12'h007;
			next_s.pins.irqDrive = 1'b1;
		end
		if (!next_s.inReset && next_s.clockCfg[`KCRC_CFG_BUF_BIT]) begin
			next_s.pins.scanOut8Clock = 1'b1;
			next_s.pins.scanOutDrive[8] = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s <= '0;
			s.rstSync <= 2'h0;
			s.porCount <= `KCRC_POR_PRESET;
			s.porActive <= 1'b1;
			s.inReset <= 1'b1;
			s.clockCfg <= `KCRC_CFG_RESET;
			s.activeSrc <= `KCRC_SRC_PRESCALED;
			s.activeTime <= ACTIVE_DEFAULT;
			s.mode <= kcrc_pkg::KCRC_RUN;
			s.pins.xtalOutPullup <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================================
	// Outputs
	assign execEnable = s.execEn;
	assign pwmTimebaseTick = s.tbTick;
	assign bufferedTimebaseOut = s.bufOut;
	assign clockConfig = s.clockCfg;
	assign coreReset = s.inReset;
	assign haltActive = s.halted;
	assign nackFirstCycle = s.nackFirst;
	assign pinControl = s.pins;

	// ==========================================================================
	// Assertions
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	a_exec_spacing: assert property (s.execEn && EXEC_DIV == 20 |=> !s.execEn [*8])
		else $error("execution enable pulses too close");
	a_halt_stops: assert property (s.halted && !s.inReset && !activity |=> !s.execEn)
		else $error("execution clock runs while halted");
	a_bus_wake: assert property (s.halted && busStart && !next_s.inReset |=> !s.halted && s.nackFirst)
		else $error("bus start did not wake with refusal");
	a_cfg_reserved: assert property ((s.clockCfg & ~`KCRC_CFG_MASK) == 8'h00)
		else $error("reserved clock config bit set");
	a_reset_defaults: assert property (s.inReset |-> s.clockCfg == `KCRC_CFG_RESET
		&& s.activeSrc == `KCRC_SRC_PRESCALED)
		else $error("clock defaults not restored in reset");
	a_switch_low: assert property ($changed(s.activeSrc) && !s.inReset |-> !$past(s.tbLevel))
		else $error("timebase source switched while high");
	a_por_preload: assert property (!supplyOk |=> s.porCount == `KCRC_POR_PRESET && s.inReset)
		else $error("power-on preload missing");
	a_pin_release: assert property ($rose(s.rstSync[1]) && !s.porActive && !resetCommand
		&& supplyOk |=> !s.inReset)
		else $error("pin reset release delayed");
	a_reset_float: assert property (s.inReset |-> s.pins.scanOutDrive == 12'h000
		&& !s.pins.irqDrive && s.pins.scanInPullup == 8'h00)
		else $error("pins not floating in reset");
	a_init_pins: assert property (s.initDone && !s.inReset |-> s.pins.scanOutDrive[2:0] == 3'h7
		&& s.pins.irqDrive && s.pins.pwmDrive == 3'h0)
		else $error("init pin setup wrong");
	a_buf_owns: assert property (s.clockCfg[`KCRC_CFG_BUF_BIT] && !s.inReset |-> s.pins.scanOut8Clock
		&& !s.pins.scanOutDrive[8])
		else $error("buffer does not own scan output 8");
	a_idle_halt: assert property (s.mode == kcrc_pkg::KCRC_RUN && !activity && !next_s.inReset
		&& s.activeTime != 8'h00 && s.idleUnits >= s.activeTime |=> s.halted)
		else $error("halt not entered after idle period");

	a_tick_single: assert property (s.tbTick |=> !s.tbTick)
		else $error("timebase tick longer than one cycle");
	a_halt_hold: assert property (s.halted && !s.inReset |=> $stable(s.execDiv))
		else $error("execution divider runs while halted");
	a_key_wake: assert property (s.halted && keyEvent && !next_s.inReset |=> !s.halted)
		else $error("key event did not wake");
	a_buf_off: assert property (!s.clockCfg[`KCRC_CFG_BUF_BIT] |=> !s.bufOut)
		else $error("buffered output runs while disabled");
	a_osc_follow: assert property (s.pins.crystalOscEnable == !s.clockCfg[`KCRC_CFG_EXTSEL_BIT])
		else $error("oscillator enable does not follow select");
	a_src_legal: assert property (s.activeSrc == `KCRC_SRC_PRESCALED
		|| s.activeSrc == `KCRC_SRC_EXTERNAL)
		else $error("reserved timebase source in use");
	a_cmd_reset: assert property (resetCommand |=> s.inReset && s.porActive
		&& s.porCount == `KCRC_POR_PRESET)
		else $error("reset command not taken");
	a_pin_entry: assert property (!s.rstSync[1] |=> s.inReset)
		else $error("pin reset not entered");
	a_por_hold: assert property (s.porActive && !s.execEn && supplyOk && !resetCommand
		|=> $stable(s.porCount))
		else $error("countdown moved without execution tick");
	a_bus_gate: assert property (s.inReset |-> !s.pins.busDataDrive && !s.pins.busClockDrive)
		else $error("bus pins driven in reset");
	a_xtal_pullup: assert property (s.pins.xtalOutPullup)
		else $error("crystal output pullup off");
	a_upper_float: assert property (s.pins.scanOutDrive[11:9] == 3'h0 && s.pins.scanOutDrive[7:3] == 5'h00
		&& s.pins.scanInPullup[7:3] == 5'h00)
		else $error("upper scan pins not floating");
	a_nack_clear: assert property (busCycleDone && !(s.mode == kcrc_pkg::KCRC_HALT && busStart)
		|=> !s.nackFirst)
		else $error("refusal not cleared by bus cycle");
	a_sync_chain: assert property ($rose(s.rstSync[1]) |-> $past(s.rstSync[0]))
		else $error("reset release skipped synchroniser stage");

	c_halt_entry: cover property ($rose(s.halted));
	c_pin_reset: cover property ($fell(s.rstSync[1]));
	c_bus_wake: cover property (s.halted && busStart ##1 s.nackFirst);
	c_ext_source: cover property ($changed(s.activeSrc) && s.activeSrc == `KCRC_SRC_EXTERNAL);
	c_por_release: cover property ($fell(s.porActive));

endmodule

// ---- verif/kcrc_host_model.sv ----
// Host-side command model driving the clock control strobes
module kcrc_host_model (
	// Clock
	input wire logic clk_sys,
	// Command strobes
	output logic clockWrite,
	output logic [7:0] clockData,
	output logic activeTimeWrite,
	output logic [7:0] activeTimeData,
	output logic initComplete,
	output logic resetCommand
);
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================================
	// Command issue
	logic clkSent = 1'b0;

	initial begin
		{clockWrite, activeTimeWrite, initComplete, resetCommand} = 4'h0;
		clockData = 8'h00;
		activeTimeData = 8'h00;
	end

	// Kind 0 clock, 1 active time, 2 init done, 3 reset; one cycle strobe
	task automatic send(input logic [1:0] kind, input logic [7:0] d);
		if (kind == 2'h0 && clkSent) begin
			return;
		end
		clkSent = (kind == 2'h0) || (clkSent && kind != 2'h3);
		@(posedge clk_sys);
		clockData <= d;
		activeTimeData <= d;
		clockWrite <= (kind == 2'h0);
		activeTimeWrite <= (kind == 2'h1);
		initComplete <= (kind == 2'h2);
		resetCommand <= (kind == 2'h3);
		@(posedge clk_sys);
		{clockWrite, activeTimeWrite, initComplete, resetCommand} <= 4'h0;
	endtask
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the keyscan clock and reset control block
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================================
	// Signals
	logic clk_sys, rstn, resetPinN, supplyOk, keyEvent, busStart, busCycleDone, busPull;
	logic encoderChange, encoderEnable, slowClockInput, crystalInPin;
	logic clockWrite, activeTimeWrite, initComplete, resetCommand;
	logic [7:0] clockData, activeTimeData, clockConfig, seed;
	logic execEnable, pwmTimebaseTick, bufferedTimebaseOut, coreReset, haltActive, nackFirstCycle;
	kcrc_pkg::kcrc_pin_type pinControl;
	int bad_count = 0;
	int tests_run = 0;
	int ph = 0;

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Slow sources with distinct periods so a wrong pick shows
	always @(posedge clk_sys) begin
		ph <= ph + 1;
		slowClockInput <= (ph % 40) < 20;
		crystalInPin <= (ph % 60) < 30;
	end

	kcrc_host_model host (.clk_sys(clk_sys), .clockWrite(clockWrite), .clockData(clockData),
		.activeTimeWrite(activeTimeWrite), .activeTimeData(activeTimeData),
		.initComplete(initComplete), .resetCommand(resetCommand));

	// Long default idle period keeps halt out of the timebase checks
	kcrc_top #(.UNIT_CYCLES(50), .EXEC_DIV(20), .ACTIVE_DEFAULT(8'hC8)) dut (.clk_sys(clk_sys), .rstn(rstn),
		.resetPinN(resetPinN), .supplyOk(supplyOk), .resetCommand(resetCommand), .clockWrite(clockWrite),
		.clockData(clockData), .activeTimeWrite(activeTimeWrite), .activeTimeData(activeTimeData),
		.initComplete(initComplete), .keyEvent(keyEvent), .busStart(busStart), .busCycleDone(busCycleDone),
		.encoderChange(encoderChange), .encoderEnable(encoderEnable), .busDataPullLow(busPull),
		.busClockPullLow(busPull), .slowClockInput(slowClockInput), .crystalInPin(crystalInPin),
		.execEnable(execEnable), .pwmTimebaseTick(pwmTimebaseTick), .bufferedTimebaseOut(bufferedTimebaseOut),
		.clockConfig(clockConfig), .coreReset(coreReset), .haltActive(haltActive),
		.nackFirstCycle(nackFirstCycle), .pinControl(pinControl));

	// ==========================================================================
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function automatic int expPeriod(input logic [7:0] c);
		if (c[1:0] != 2'h3) begin
			return 20 * 64;
		end
		return c[3] ? 40 : 60;
	endfunction

	task automatic check(input logic ok, input string what);
		tests_run++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("Error at %0t: %s", $time, what);
		end
	endtask

	task automatic waitLevel(ref logic s, input logic v, input int lim, output int n);
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask

	// Second interval is used: the first may straddle a source switch
	task automatic period(ref logic s, output int p);
		int n;
		for (int i = 0; i < 2; i++) begin
			waitLevel(s, 1'b1, 3000, n);
			@(posedge clk_sys);
			#1;
			waitLevel(s, 1'b1, 3000, p);
		end
		p++;
	endtask

	task automatic strobe(input logic [3:0] m);
		@(posedge clk_sys);
		{busCycleDone, encoderChange, busStart, keyEvent} <= m;
		@(posedge clk_sys);
		{busCycleDone, encoderChange, busStart, keyEvent} <= 4'h0;
		#1;
	endtask

	task automatic results;
		$display("Checks run %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========================================================================
	// Sequence
	initial begin
		int n;
		logic [7:0] c;
		{rstn, supplyOk, keyEvent, busStart, busCycleDone, encoderChange} = 6'h00;
		resetPinN = 1'b1;
		busPull = 1'b1;
		encoderEnable = 1'b1;
		seed = 8'h2D;
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (100) @(posedge clk_sys);
		#1;
		check(coreReset === 1'b1 && clockConfig === 8'h08, "held while supply low");
		check(pinControl.scanOutDrive === 12'h000 && pinControl.irqDrive === 1'b0, "pins float");
		check(pinControl.xtalOutPullup === 1'b1 && pinControl.pwmDrive === 3'h0, "pullup only");
		check(pinControl.busDataDrive === 1'b0 && pinControl.busClockDrive === 1'b0, "bus gated");
		@(posedge clk_sys);
		supplyOk <= 1'b1;
		waitLevel(coreReset, 1'b0, 6000, n);
		check(n >= 5100 && n <= 5200, "countdown length");
		period(execEnable, n);
		check(n == 20, "exec rate");
		check(pinControl.busDataDrive === 1'b1 && pinControl.busClockDrive === 1'b1, "bus drive");
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			c = {seed[7:2], 2'(k)};
			host.send(2'h3, 8'h00);
			#1;
			waitLevel(coreReset, 1'b0, 6000, n);
			check(clockConfig === 8'h08, "default config");
			host.send(2'h0, c);
			#1;
			check(clockConfig === (c & 8'h4B), "config bits");
			check(pinControl.scanOut8Clock === c[6], "pin takeover");
			check(pinControl.crystalOscEnable === ~c[3], "oscillator enable");
			period(pwmTimebaseTick, n);
			check(n == expPeriod(c), "timebase period");
			waitLevel(bufferedTimebaseOut, 1'b1, 1400, n);
			check((n < 1400) === c[6], "buffer output");
		end
		host.send(2'h2, 8'h00);
		#1;
		check(pinControl.scanInPullup === 8'h07 && pinControl.scanOutDrive === 12'h007, "init pins");
		check(pinControl.irqDrive === 1'b1 && pinControl.pwmDrive === 3'h0, "init irq");
		// Activity first so the idle count starts from zero
		strobe(4'h1);
		host.send(2'h1, 8'h03);
		for (int w = 0; w < 3; w++) begin
			waitLevel(haltActive, 1'b1, 400, n);
			check(n >= 100 && n <= 300, "halt entry");
			@(posedge clk_sys);
			#1;
			waitLevel(execEnable, 1'b1, 60, n);
			check(n == 60, "exec stopped");
			if (w == 1) begin
				@(posedge clk_sys);
				encoderEnable <= 1'b0;
				strobe(4'h4);
				check(haltActive === 1'b1, "masked encoder");
				@(posedge clk_sys);
				encoderEnable <= 1'b1;
			end
			strobe({1'b0, w == 1, w == 2, w == 0});
			check(haltActive === 1'b0 && nackFirstCycle === (w == 2), "wake");
		end
		strobe(4'h8);
		strobe(4'h2);
		check(nackFirstCycle === 1'b0, "repeat accepted");
		@(posedge clk_sys);
		resetPinN <= 1'b0;
		waitLevel(coreReset, 1'b1, 10, n);
		check(n <= 4 && pinControl.scanOutDrive === 12'h000, "pin reset entry");
		repeat (28) @(posedge clk_sys);
		resetPinN <= 1'b1;
		waitLevel(coreReset, 1'b0, 60, n);
		check(n <= 56, "pin reset release");
		results();
	end

	// Longest path is five countdowns plus periods, well below this
	initial begin
		repeat (80000) @(posedge clk_sys);
		bad_count++;
		results();
	end
endmodule
